// file: verilog/fmpc_pkg.sv
// Constants and types shared by the frame memory pointer control block
package fmpc_pkg;
    localparam int          DATA_W     = 12;
    localparam int          JUMP_W     = 24;
    // Register byte offsets
    localparam logic [7:0]  OFS_CFG    = 8'h00;
    localparam logic [7:0]  OFS_TRIG   = 8'h04;
    localparam logic [7:0]  OFS_JMPA   = 8'h08;
    localparam logic [7:0]  OFS_JMPB   = 8'h0c;
    localparam logic [7:0]  OFS_WPTRA  = 8'h10;
    localparam logic [7:0]  OFS_RPTRA  = 8'h14;
    // Configuration register field positions
    localparam int          CFG_MODE   = 0;
    localparam int          CFG_MSEL   = 3;
    localparam int          CFG_WID    = 6;
    // Trigger style bits, 0 = falling edge, 1 = low level
    localparam int          TRG_CLR_A  = 0;
    localparam int          TRG_SET_A  = 1;
    localparam int          TRG_CLR_B  = 2;
    localparam int          TRG_SET_B  = 3;
    localparam int          TRG_CLR_R  = 4;
    localparam int          TRG_SET_R  = 5;
    // Width codes
    localparam logic [1:0]  WID_8      = 2'h1;
    localparam logic [1:0]  WID_10     = 2'h2;
    // Reset values
    localparam logic [2:0]  MODE_RST   = 3'h7;
    localparam logic [1:0]  WID_RST    = WID_10;
    localparam logic [5:0]  TRIG_RST   = 6'h00;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    typedef struct packed {
        logic [2:0]        mode;
        logic [1:0]        width;
        logic              msel;
        logic [5:0]        trig;
        logic [JUMP_W-1:0] ja;
        logic [JUMP_W-1:0] jb;
    } fmpc_cfg_t;

    localparam fmpc_cfg_t CFG_RST = '{MODE_RST, WID_RST, 1'b0, TRIG_RST,
                                      24'h000000, 24'h000000};
endpackage

// file: verilog/fmpc_top.sv
// Frame memory write/read pointer control with AXI4-Lite configuration
// Contract
// - Two-channel modes drive port B out; 10-bit floats bits 1:0, 8-bit bits 3:0.
// - One-channel read set uses B-out pins only if A read on, mark-sel and B-clear high.
// - Write set uses B-out pins only if A write on, A clear high, B set high.
// - After A clear falls, next A write lands at address zero.
// - A clear edge or level; level holds write address zero while low.
// - A clear and set act only while A write enable is low.
// - B clear clears B write pointer in two-channel modes, else steers read set.
// - A set with A clear high writes at jump address, or pin coordinates.
// - With A clear and set high, writes go to next higher address.
// - A set edge overrides one write; level overrides continuously.
// - B set acts on B pointer in two-channel modes, else picks jump or pins.
// - A mark captures write pointer, pointer itself unchanged.
// - B mark captures B write pointer in two-channel modes only.
// - Two-channel read set loads jump or mark per enabled channel.
// - One-channel read set loads mark, B jump, or pin coordinates.
// - Read set is edge or level programmable.
// - Read clear zeroes each enabled read pointer at next read clock edge.
// - Write enable high ignores data and holds pointer; low writes on edge.
// - Write mask blocks storage but pointer still advances.
// - Read enable high holds output and read pointer; low updates each edge.
// - Load low copies preload into working config; high leaves it untouched.
// - Reset zeroes pointers; config defaults only when load also low.
// - Per-control trigger bit, zero default means falling edge.
// - Three-bit mode field, default 111 two-channel queue.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fmpc_top
    import fmpc_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic                MCLK,
    input  wire logic                RST_N,
    // AXI4-Lite slave
    input  wire logic [7:0]          S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output var  logic                S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output var  logic                S_AXI_WREADY,
    output var  logic [1:0]          S_AXI_BRESP,
    output var  logic                S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [7:0]          S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output var  logic                S_AXI_ARREADY,
    output var  logic [31:0]         S_AXI_RDATA,
    output var  logic [1:0]          S_AXI_RRESP,
    output var  logic                S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    // Video clocks and data pins
    input  wire logic                WRITE_CLOCK_A,
    input  wire logic                WRITE_CLOCK_B,
    input  wire logic                READ_CLOCK,
    input  wire logic [DATA_W-1:0]   IN_PORT_A,
    input  wire logic [DATA_W-1:0]   IN_PORT_B,
    output var  logic [DATA_W-1:0]   OUT_PORT_A,
    input  wire logic [DATA_W-1:0]   OUT_PORT_B_I,
    output var  logic [DATA_W-1:0]   OUT_PORT_B_O,
    output var  logic [DATA_W-1:0]   OUT_PORT_B_OE,
    // Pointer controls, active low except the two write masks
    input  wire logic                WRITE_ENABLE_A_N,
    input  wire logic                WRITE_ENABLE_B_N,
    input  wire logic                READ_ENABLE_A_N,
    input  wire logic                READ_ENABLE_B_N,
    input  wire logic                WRITE_MASK_A,
    input  wire logic                WRITE_MASK_B,
    input  wire logic                CLEAR_WPTR_A_N,
    input  wire logic                CLEAR_WPTR_B_OR_SEL_N,
    input  wire logic                SET_WPTR_A_N,
    input  wire logic                SET_WPTR_B_OR_SRC_SEL_N,
    input  wire logic                MARK_WPTR_A_N,
    input  wire logic                MARK_WPTR_B_N,
    input  wire logic                SET_RPTR_N,
    input  wire logic                CLEAR_RPTR_N,
    input  wire logic                CFG_LOAD_N,
    input  wire logic                DEV_RESET_N
);
    import fmpc_pkg::*;

    localparam int SW = 19 + 3 * DATA_W;

    // all pins resampled into the one clock
    // Every pin passes two flops; the third stage only feeds edge detection
    logic [SW-1:0] s1_reg;
    logic [SW-1:0] s2_reg;
    logic [SW-1:0] s3_reg;
    wire  [SW-1:0] pins = {WRITE_CLOCK_A, WRITE_CLOCK_B, READ_CLOCK,
        WRITE_ENABLE_A_N, WRITE_ENABLE_B_N, READ_ENABLE_A_N, READ_ENABLE_B_N,
        WRITE_MASK_A, WRITE_MASK_B, CLEAR_WPTR_A_N, CLEAR_WPTR_B_OR_SEL_N,
        SET_WPTR_A_N, SET_WPTR_B_OR_SRC_SEL_N, MARK_WPTR_A_N, MARK_WPTR_B_N,
        SET_RPTR_N, CLEAR_RPTR_N, CFG_LOAD_N, DEV_RESET_N,
        IN_PORT_A, IN_PORT_B, OUT_PORT_B_I};

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    logic              wca, wcb, rck, wen_a, wen_b, ren_a, ren_b, msk_a, msk_b;
    logic              clr_a, clr_b, set_a, set_b, mrk_a, mrk_b, set_rptr, clear_rptr;
    logic              load_n, dres_n;
    logic [DATA_W-1:0] in_a, in_b, outb_i;
    logic              p_wca, p_wcb, p_rck, p_wen_a, p_wen_b, p_ren_a, p_ren_b;
    logic              p_msk_a, p_msk_b, p_clr_a, p_clr_b, p_set_a, p_set_b;
    logic              p_mrk_a, p_mrk_b, p_set_rptr, p_clear_rptr, p_load, p_dres;
    logic [DATA_W-1:0] p_in_a, p_in_b, p_outb;
    assign {wca, wcb, rck, wen_a, wen_b, ren_a, ren_b, msk_a, msk_b, clr_a,
            clr_b, set_a, set_b, mrk_a, mrk_b, set_rptr, clear_rptr, load_n, dres_n,
            in_a, in_b, outb_i} = s2_reg;
    assign {p_wca, p_wcb, p_rck, p_wen_a, p_wen_b, p_ren_a, p_ren_b, p_msk_a,
            p_msk_b, p_clr_a, p_clr_b, p_set_a, p_set_b, p_mrk_a, p_mrk_b,
            p_set_rptr, p_clear_rptr, p_load, p_dres, p_in_a, p_in_b, p_outb} = s3_reg;

    // Configuration: preload written by software, working used by logic
    fmpc_cfg_t pre_reg;
    fmpc_cfg_t work_reg;
    // mode field top bit selects two channels
    wire       two_ch = work_reg.mode[2];
    wire [5:0] trg    = work_reg.trig;
    wire       msel   = work_reg.msel;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [ADDR_W-1:0] pick(input logic ce,
                                               input logic se,
                                               input logic [ADDR_W-1:0] alt,
                                               input logic [ADDR_W-1:0] ptr);
        return ce ? '0 : (se ? alt : ptr);
    endfunction

    function automatic logic [DATA_W-1:0] lanes(input logic [1:0] w);
        case (w)
            WID_8:   return 12'hff0;
            WID_10:  return 12'hffc;
            default: return 12'hfff;
        endcase
    endfunction

    // AXI4-Lite slave
    logic        awr_reg, wr_reg, bv_reg, arr_reg, rv_reg;
    logic        aw_have, w_have;
    logic [7:0]  awa_reg;
    logic [31:0] wd_reg, rd_reg;
    logic [3:0]  ws_reg;
    logic [1:0]  br_reg, rr_reg;
    logic [ADDR_W-1:0] wptr_a, wptr_b, rptr_a, rptr_b;
    wire  do_write = aw_have && w_have && !bv_reg;

    function automatic logic [31:0] cfg_word(input fmpc_cfg_t c);
        logic [31:0] r;
        r = '0;
        r[CFG_MODE +: 3] = c.mode;
        r[CFG_MSEL]      = c.msel;
        r[CFG_WID +: 2]  = c.width;
        return r;
    endfunction

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            awr_reg <= 1'b1;
            wr_reg  <= 1'b1;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            awa_reg <= 8'h00;
            wd_reg  <= 32'h00000000;
            ws_reg  <= 4'h0;
            bv_reg  <= 1'b0;
            br_reg  <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && awr_reg) begin
                awa_reg <= S_AXI_AWADDR;
                aw_have <= 1'b1;
                awr_reg <= 1'b0;
            end
            if (S_AXI_WVALID && wr_reg) begin
                wd_reg <= S_AXI_WDATA;
                ws_reg <= S_AXI_WSTRB;
                w_have <= 1'b1;
                wr_reg <= 1'b0;
            end
            if (do_write) begin
                aw_have <= 1'b0;
                w_have  <= 1'b0;
                bv_reg  <= 1'b1;
                br_reg  <= (awa_reg <= OFS_JMPB && awa_reg[1:0] == 2'h0)
                           ? RESP_OKAY : RESP_SLV;
            end
            if (bv_reg && S_AXI_BREADY) begin
                bv_reg  <= 1'b0;
                awr_reg <= 1'b1;
                wr_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            arr_reg <= 1'b1;
            rv_reg  <= 1'b0;
            rd_reg  <= 32'h00000000;
            rr_reg  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && arr_reg) begin
            arr_reg <= 1'b0;
            rv_reg  <= 1'b1;
            rr_reg  <= RESP_OKAY;
            case (S_AXI_ARADDR)
                OFS_CFG:   rd_reg <= cfg_word(pre_reg);
                OFS_TRIG:  rd_reg <= {26'h0, pre_reg.trig};
                OFS_JMPA:  rd_reg <= {8'h00, pre_reg.ja};
                OFS_JMPB:  rd_reg <= {8'h00, pre_reg.jb};
                OFS_WPTRA: rd_reg <= {{(32-ADDR_W){1'b0}}, wptr_a};
                OFS_RPTRA: rd_reg <= {{(32-ADDR_W){1'b0}}, rptr_a};
                default: begin
                    rd_reg <= 32'h00000000;
                    rr_reg <= RESP_SLV;
                end
            endcase
        end else if (rv_reg && S_AXI_RREADY) begin
            rv_reg  <= 1'b0;
            arr_reg <= 1'b1;
        end
    end

    assign S_AXI_AWREADY = awr_reg;
    assign S_AXI_WREADY  = wr_reg;
    assign S_AXI_BVALID  = bv_reg;
    assign S_AXI_BRESP   = br_reg;
    assign S_AXI_ARREADY = arr_reg;
    assign S_AXI_RVALID  = rv_reg;
    assign S_AXI_RDATA   = rd_reg;
    assign S_AXI_RRESP   = rr_reg;

    // Word under write, so byte strobes merge into the stored value
    logic [31:0] old_word;
    logic [31:0] new_word;
    always_comb begin
        case (awa_reg)
            OFS_CFG:  old_word = cfg_word(pre_reg);
            OFS_TRIG: old_word = {26'h0, pre_reg.trig};
            OFS_JMPA: old_word = {8'h00, pre_reg.ja};
            OFS_JMPB: old_word = {8'h00, pre_reg.jb};
            default:  old_word = 32'h00000000;
        endcase
    end
    assign new_word = merge(old_word, wd_reg, ws_reg);

    // Preload latches; device reset restores defaults only with load low
    // conditional default
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_reg <= CFG_RST;
        end else if (!dres_n && !load_n) begin
            pre_reg <= CFG_RST;
        end else if (do_write) begin
            case (awa_reg)
                OFS_CFG: begin
                    pre_reg.mode  <= new_word[CFG_MODE +: 3];
                    pre_reg.msel  <= new_word[CFG_MSEL];
                    pre_reg.width <= new_word[CFG_WID +: 2];
                end
                OFS_TRIG: pre_reg.trig <= new_word[5:0];
                OFS_JMPA: pre_reg.ja <= new_word[23:0];
                OFS_JMPB: pre_reg.jb <= new_word[23:0];
                default: pre_reg <= pre_reg;
            endcase
        end
    end

    // working tracks preload while load is low
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            work_reg <= CFG_RST;
        end else if (!dres_n && !load_n) begin
            work_reg <= CFG_RST;
        end else if (!load_n) begin
            work_reg <= pre_reg;
        end
    end

    // Edge events on the synchronised pins
    wire wrise_a = wca & ~p_wca;
    wire wrise_b = wcb & ~p_wcb;
    wire rrise   = rck & ~p_rck;
    wire [ADDR_W-1:0] cart = ADDR_W'({outb_i, in_b});

    // Falling-edge requests wait for the next enabled write edge, or for any read clock edge
    logic pca, psa, pcb, psb, prc, prs;
    wire do_wa = wrise_a & ~wen_a;
    wire do_wb = two_ch & wrise_b & ~wen_b;
    wire ce_a  = trg[TRG_CLR_A] ? ~clr_a : pca;
    // set overrides only while clear high
    wire se_a  = clr_a & (trg[TRG_SET_A] ? ~set_a : psa);
    wire ce_b  = trg[TRG_CLR_B] ? ~clr_b : pcb;
    wire se_b  = clr_b & (trg[TRG_SET_B] ? ~set_b : psb);
    wire rce   = trg[TRG_CLR_R] ? ~clear_rptr : prc;
    wire rse   = trg[TRG_SET_R] ? ~set_rptr : prs;
    // pin coordinates only with B set high in one-channel modes
    wire [ADDR_W-1:0] alt_a = (!two_ch && set_b) ? cart : work_reg.ja[ADDR_W-1:0];
    wire [ADDR_W-1:0] wa_addr = pick(ce_a, se_a, alt_a, wptr_a);
    // B pointer set to B jump address
    wire [ADDR_W-1:0] wb_addr = pick(ce_b, se_b, work_reg.jb[ADDR_W-1:0], wptr_b);

    // pending requests held until an enabled write edge; read requests until any read clock edge
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            {pca, psa, pcb, psb, prc, prs} <= 6'h00;
        end else if (!dres_n) begin
            {pca, psa, pcb, psb, prc, prs} <= 6'h00;
        end else begin
            pca <= (p_clr_a & ~clr_a) | (pca & ~do_wa);
            psa <= (p_set_a & ~set_a) | (psa & ~(do_wa & clr_a));
            pcb <= (p_clr_b & ~clr_b) | (pcb & ~do_wb);
            psb <= (p_set_b & ~set_b) | (psb & ~(do_wb & clr_b));
            prc <= (p_clear_rptr & ~clear_rptr) | (prc & ~rrise);
            prs <= (p_set_rptr & ~set_rptr) | (prs & ~rrise);
        end
    end

    // pointers forced to zero; otherwise advance
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wptr_a <= '0;
            wptr_b <= '0;
        end else if (!dres_n) begin
            wptr_a <= '0;
            wptr_b <= '0;
        end else begin
            if (do_wa) begin
                wptr_a <= wa_addr + 1'b1;
            end
            // B clear acts on B pointer in two-channel modes
            if (do_wb) begin
                wptr_b <= wb_addr + 1'b1;
            end
        end
    end

    // Core arrays; depth is kept small by ADDR_W for simulation
    logic [DATA_W-1:0] mem_a [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] mem_b [0:(1<<ADDR_W)-1];
    // mask blocks storage only; clear lands at zero
    always_ff @(posedge MCLK) begin
        if (do_wa && !msk_a) begin
            mem_a[wa_addr] <= in_a;
        end
        if (do_wb && !msk_b) begin
            mem_b[wb_addr] <= in_b;
        end
    end

    logic [ADDR_W-1:0] mark_a, mark_b;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            mark_a <= '0;
            mark_b <= '0;
        end else if (!dres_n) begin
            mark_a <= '0;
            mark_b <= '0;
        end else begin
            if (p_mrk_a && !mrk_a) begin
                mark_a <= wptr_a;
            end
            if (two_ch && p_mrk_b && !mrk_b) begin
                mark_b <= wptr_b;
            end
        end
    end

    // one-channel read set source; two-channel per channel
    wire [ADDR_W-1:0] one_set = !msel ? mark_a : (clr_b ? cart : work_reg.jb[ADDR_W-1:0]);
    wire [ADDR_W-1:0] a_set   = two_ch ? (msel ? work_reg.ja[ADDR_W-1:0] : mark_a) : one_set;
    wire [ADDR_W-1:0] b_set   = msel ? work_reg.jb[ADDR_W-1:0] : mark_b;
    wire [ADDR_W-1:0] ra_tgt  = pick(rce, rse, a_set, rptr_a);
    wire [ADDR_W-1:0] rb_tgt  = pick(rce, rse, b_set, rptr_b);
    wire do_ra = rrise & ~ren_a;
    wire do_rb = two_ch & rrise & ~ren_b;

    logic [DATA_W-1:0] out_a_reg, out_b_reg, oe_b_reg;
    // output register and pointer hold while read enable high
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rptr_a    <= '0;
            rptr_b    <= '0;
            out_a_reg <= 12'h000;
            out_b_reg <= 12'h000;
        end else if (!dres_n) begin
            rptr_a    <= '0;
            rptr_b    <= '0;
        end else begin
            if (do_ra) begin
                rptr_a    <= ra_tgt + 1'b1;
                out_a_reg <= mem_a[ra_tgt];
            end
            if (do_rb) begin
                rptr_b    <= rb_tgt + 1'b1;
                out_b_reg <= mem_b[rb_tgt];
            end
        end
    end

    // port B drives only in two-channel modes, width lanes
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            oe_b_reg <= 12'h000;
        end else begin
            oe_b_reg <= two_ch ? lanes(work_reg.width) : 12'h000;
        end
    end

    assign OUT_PORT_A    = out_a_reg;
    assign OUT_PORT_B_O  = out_b_reg;
    assign OUT_PORT_B_OE = oe_b_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    wen_hold_a: assert property (wrise_a && wen_a && dres_n |=> $stable(wptr_a))
        else $error("write pointer A moved with enable high");
    lvl_clr_a: assert property (do_wa && trg[TRG_CLR_A] && !clr_a && dres_n
                                |=> wptr_a == 1)
        else $error("level clear did not hold address zero");
    seq_inc_a: assert property (do_wa && !ce_a && !se_a && dres_n
                                |=> wptr_a == $past(wptr_a) + 1'b1)
        else $error("write pointer A did not step");
    mark_keep_a: assert property (p_mrk_a && !mrk_a && !do_wa && dres_n
                                  |=> $stable(wptr_a) && mark_a == $past(wptr_a))
        else $error("mark A wrong");
    rd_hold_a: assert property (rrise && ren_a && dres_n
                                |=> $stable(out_a_reg) && $stable(rptr_a))
        else $error("read side A moved with enable high");
    clear_rptr_zero_a: assert property (do_ra && rce && dres_n |=> rptr_a == 1)
        else $error("read clear missed");
    ptr_reset_a: assert property (!dres_n |=> wptr_a == 0 && rptr_a == 0 && wptr_b == 0)
        else $error("pointers not zero in reset");
    load_hold_a: assert property (load_n |=> $stable(work_reg))
        else $error("working config changed with load high");
    boe_off_a: assert property (!two_ch |=> OUT_PORT_B_OE == 12'h000)
        else $error("port B driven in one-channel mode");
    mark_wptr_b_gate_a: assert property (!two_ch && dres_n |=> $stable(mark_b))
        else $error("mark B moved in one-channel mode");

    cov_write_a: cover property (do_wa && se_a);
    cov_set_rptr_a:  cover property (do_ra && rse && !rce);
    cov_two_b:   cover property (do_rb);
endmodule
`default_nettype wire

// file: tb/fmpc_vid.sv
// Far-side video model: write and read clock pulses, moving B pins
`timescale 1ns/1ns
`default_nettype none
module fmpc_vid (
    // Clock and requests
    input  wire logic   MCLK,
    input  wire logic   wr_go,
    input  wire logic   rd_go,
    // Video pins
    output logic        WRITE_CLOCK_A,
    output logic        READ_CLOCK,
    output logic [11:0] PAT
);
    logic [3:0]  wn = 4'h0;
    logic [3:0]  rn = 4'h0;
    logic [11:0] pat = 12'h0;
    // Clocks stand low outside frames; four cycles high then four low
    always @(posedge MCLK) begin
        wn <= wr_go ? 4'h8 : wn - {3'h0, |wn};
        rn <= rd_go ? 4'h8 : rn - {3'h0, |rn};
        pat <= pat + 12'h5a3;
    end
    assign WRITE_CLOCK_A = wn > 4'h4;
    assign READ_CLOCK = rn > 4'h4;
    assign PAT = pat;
endmodule
`default_nettype wire

// file: tb/fmpc_bench.sv
// Self-checking bench for the frame memory pointer control block
`timescale 1ns/1ns
`default_nettype none
module frame_memory_pointer_control_bench;
    import fmpc_pkg::*;
    logic MCLK = '0, RST_N = '0, wr_go = '0, rd_go = '0, vid_ev = '0;
    logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0, S_AXI_ARVALID = '0;
    logic S_AXI_RREADY = '0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, WRITE_CLOCK_A, READ_CLOCK, WRITE_ENABLE_A_N = '0;
    logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [11:0] IN_PORT_A = '0, OUT_PORT_A, OUT_PORT_B_O, OUT_PORT_B_OE, PAT;
    logic READ_ENABLE_A_N = '0, READ_ENABLE_B_N = '0, WRITE_MASK_A = '0;
    logic CLEAR_WPTR_A_N = '1, CLEAR_WPTR_B_OR_SEL_N = '1, SET_WPTR_A_N = '1;
    logic SET_WPTR_B_OR_SRC_SEL_N = '1, MARK_WPTR_A_N = '1, MARK_WPTR_B_N = '1;
    logic SET_RPTR_N = '1, CLEAR_RPTR_N = '1, CFG_LOAD_N = '0, DEV_RESET_N = '0;
    wire logic WRITE_CLOCK_B = WRITE_CLOCK_A, WRITE_MASK_B = WRITE_MASK_A;
    wire logic WRITE_ENABLE_B_N = WRITE_ENABLE_A_N;
    wire logic [11:0] IN_PORT_B = PAT, OUT_PORT_B_I = ~PAT;
    int failures = 0, n_tests = 0, seed = 72;
    logic [33:0] q[$];
    logic [11:0] d[4];
    fmpc_top #(.ADDR_W(10)) DUT (.*);
    fmpc_vid FAR (.*);
    initial forever #4 MCLK = ~MCLK;
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int i;
        @(posedge MCLK);
        q.push_back({RESP_OKAY, 32'h0});
        {S_AXI_AWADDR, S_AXI_WDATA} <= {a, v};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        for (i = 0; i < 50; i++) begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= '0;
            if (S_AXI_WREADY) S_AXI_WVALID <= '0;
            if (S_AXI_BVALID) break;
        end
        S_AXI_BREADY <= '0;
        if (i == 50) begin
            failures++;
            stop_test;
        end
    endtask
    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        int i;
        @(posedge MCLK);
        q.push_back(e);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        for (i = 0; i < 50; i++) begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= '0;
            if (S_AXI_RVALID) break;
        end
        S_AXI_RREADY <= '0;
        if (i == 50) begin
            failures++;
            stop_test;
        end
    endtask
    // one video clock pulse, enables and data a cycle ahead of it
    task automatic vid(input logic r, input logic [11:0] v);
        @(posedge MCLK);
        if (r) q.push_back({22'h0, v});
        IN_PORT_A <= v;
        {wr_go, rd_go} <= {!r, r};
        @(posedge MCLK);
        {wr_go, rd_go} <= 2'h0;
        repeat (10) @(posedge MCLK);
        vid_ev <= r;
        @(posedge MCLK);
        vid_ev <= '0;
    endtask
    always @(posedge MCLK) begin
        if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY)
            chk("rdata", q.pop_front(), {S_AXI_RRESP, S_AXI_RDATA});
        else if (S_AXI_BVALID === 1'b1 && S_AXI_BREADY)
            chk("bresp", q.pop_front(), {S_AXI_BRESP, 32'h0});
        else if (vid_ev)
            chk("out_a", q.pop_front(), {22'h0, OUT_PORT_A});
    end
    initial begin
        repeat (2) @(posedge MCLK);
        {RST_N, DEV_RESET_N} <= 2'h3;
        axr(OFS_CFG, 34'h87);
        axr(OFS_TRIG, 34'h0);
        axr(8'h40, {RESP_SLV, 32'h0});
        CFG_LOAD_N <= '1;
        axw(OFS_CFG, 32'h47);
        repeat (4) @(posedge MCLK);
        chk("oe", 34'hffc, {22'h0, OUT_PORT_B_OE});
        CFG_LOAD_N <= '0;
        repeat (5) @(posedge MCLK);
        chk("oe", 34'hff0, {22'h0, OUT_PORT_B_OE});
        CFG_LOAD_N <= '1;
        axw(OFS_CFG, 32'hc7);
        CFG_LOAD_N <= '0;
        repeat (5) @(posedge MCLK);
        chk("oe", 34'hfff, {22'h0, OUT_PORT_B_OE});
        $display("config test done");
        CLEAR_WPTR_A_N <= '0;
        repeat (4) @(posedge MCLK);
        CLEAR_WPTR_A_N <= '1;
        for (int k = 0; k < 4; k++) d[k] = 12'($random(seed));
        for (int k = 0; k < 3; k++) vid(0, d[k]);
        axr(OFS_WPTRA, 34'h3);
        WRITE_ENABLE_A_N <= '1;
        vid(0, ~d[0]);
        WRITE_ENABLE_A_N <= '0;
        axr(OFS_WPTRA, 34'h3);
        WRITE_MASK_A <= '1;
        vid(0, ~d[1]);
        WRITE_MASK_A <= '0;
        MARK_WPTR_A_N <= '0;
        repeat (4) @(posedge MCLK);
        MARK_WPTR_A_N <= '1;
        vid(0, d[3]);
        axr(OFS_WPTRA, 34'h5);
        $display("write test done");
        CLEAR_RPTR_N <= '0;
        repeat (4) @(posedge MCLK);
        CLEAR_RPTR_N <= '1;
        for (int k = 0; k < 3; k++) vid(1, d[k]);
        READ_ENABLE_A_N <= '1;
        vid(1, d[2]);
        READ_ENABLE_A_N <= '0;
        SET_RPTR_N <= '0;
        repeat (4) @(posedge MCLK);
        SET_RPTR_N <= '1;
        vid(1, d[3]);
        axr(OFS_RPTRA, 34'h5);
        $display("read test done");
        CFG_LOAD_N <= '1;
        axw(OFS_JMPA, 32'h10);
        CFG_LOAD_N <= '0;
        SET_WPTR_A_N <= '0;
        repeat (4) @(posedge MCLK);
        SET_WPTR_A_N <= '1;
        vid(0, d[0]);
        vid(0, d[1]);
        axr(OFS_WPTRA, 34'h12);
        $display("jump test done");
        CFG_LOAD_N <= '1;
        axw(OFS_TRIG, 32'h1);
        {CFG_LOAD_N, CLEAR_WPTR_A_N} <= 2'h0;
        vid(0, d[2]);
        vid(0, d[3]);
        CLEAR_WPTR_A_N <= '1;
        axr(OFS_WPTRA, 34'h1);
        $display("level test done");
        CFG_LOAD_N <= '1;
        DEV_RESET_N <= '0;
        repeat (4) @(posedge MCLK);
        {DEV_RESET_N, CFG_LOAD_N} <= 2'h2;
        axr(OFS_WPTRA, 34'h0);
        axr(OFS_RPTRA, 34'h0);
        axr(OFS_CFG, 34'hc7);
        DEV_RESET_N <= '0;
        repeat (4) @(posedge MCLK);
        DEV_RESET_N <= '1;
        axr(OFS_TRIG, 34'h0);
        $display("reset test done");
        stop_test;
    end
endmodule
`default_nettype wire
